// ===== core/fee_fault_unit.v
/*
  Fault exception unit: classifies memory protection, bus error and program
  usage faults, pends them, escalates to the catch-all fault, arbitrates
  against the running level and the mask, and flags lockup.
  Assumes pipeline event pulses on SYS_CLK, an APB master on the same clock,
  and a pipeline that answers TAKE_* by entering/leaving handlers.
*/
`timescale 1ns/1ps
`include "fee_regs.vh"

// How it works
// RULE1: Catch-all fault is number 3, level -1
// RULE2: Faults 4,5,6 use programmable priorities
// RULE3: Faults 4,5,6 disabled after reset
// RULE4: Disabled or nested fault goes to catch-all
// RULE5: Priority and mask decide entry and preemption
// RULE6: Same-kind fault in own handler escalates
// RULE7: Fault not above serviced fault escalates
// RULE8: Fault not above current level escalates
// RULE9: Disabled configurable fault becomes catch-all
// RULE10: Bus error on bus-handler push stays
// RULE11: Only reset and NMI preempt catch-all
// RULE12: Status records precise and imprecise flags
// RULE13: Precise bus error raised at transfer end
// RULE14: Precise error in NMI/catch-all locks up
// RULE15: Debugger bus errors go to debug only
// RULE16: Imprecise error pends, pipeline keeps going
// RULE17: Higher interrupt served before pended bus error
// RULE18: Imprecise with bus handler off pends catch-all
// RULE19: Imprecise-origin catch-all never locks up (a precise bus, protection or usage fault in it still locks up here)
// RULE20: Protection violations raise protection fault
// RULE21: Fetch, data, vector, stacking errors raise bus
// RULE22: Undefined, multi-unaligned always; others when enabled
// RULE23: Control bits enable divide and unaligned traps
// RULE24: Handler state holds enable, pend, active bits
// RULE25: Highest priority wins, ties lowest number
module fee_fault_unit (
  input  wire        SYS_CLK,
  input  wire        RST_N,
  // APB slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // Pipeline fault events, one-cycle pulses
  input  wire        MPU_VIOLATION,
  input  wire        BUS_ERR_PRECISE,
  input  wire        BUS_ERR_IMPRECISE,
  input  wire        BUS_ERR_DEBUG,
  input  wire        BUS_ERR_BE_PUSH,
  input  wire        UNDEF_INSTR,
  input  wire        UNALIGNED_MULTI,
  input  wire        UNALIGNED_SINGLE,
  input  wire        DIV_BY_ZERO,
  // Running state from the pipeline
  input  wire [9:0]  CUR_LEVEL,
  input  wire [3:0]  CUR_EXC,
  input  wire        MASK_ALL,
  input  wire        MASK_FAULT,
  input  wire [9:0]  IRQ_LEVEL,
  input  wire        IRQ_REQ,
  input  wire        EXC_RETURN,
  // Decisions to the pipeline
  output reg         TAKE_VALID,
  output reg  [3:0]  TAKE_EXC,
  output reg         DIV_ZERO_QUIET,
  output reg         DEBUG_BUS_ERR,
  output reg         LOCKUP
);

  // ********************************************************
  // Registers
  // ********************************************************
  reg [31:0] prio_ff;
  reg        trap_div_ff, trap_unal_ff;
  reg        ena_mp_ff, ena_be_ff, ena_pu_ff;
  reg        pend_mp_ff, pend_be_ff, pend_pu_ff, pend_caf_ff;
  reg        act_mp_ff, act_be_ff, act_pu_ff, act_caf_ff;
  reg        bes_prec_ff, bes_imp_ff;
  reg        caf_imp_ff;
  reg        nxt_pend_mp, nxt_pend_be, nxt_pend_pu, nxt_pend_caf;
  reg        nxt_lockup, nxt_caf_imp;
  reg [3:0]  nxt_take;

  wire [7:0] lvl_mp = prio_ff[`FEE_PRIO_MP_LSB +: 8];
  wire [7:0] lvl_be = prio_ff[`FEE_PRIO_BE_LSB +: 8];
  wire [7:0] lvl_pu = prio_ff[`FEE_PRIO_PU_LSB +: 8];

  // Signed compare on 10-bit levels: fault level strictly above running level
  function preempts;
    input [7:0] lvl;
    input [9:0] cur;
    begin
      preempts = ($signed({2'b00, lvl}) < $signed(cur));
    end
  endfunction

  // ********************************************************
  // APB access decode
  // ********************************************************
  wire acc    = PSEL & PENABLE & ~PREADY;
  wire wr_acc = acc & PWRITE;
  wire wr_cfg = wr_acc && (PADDR == `FEE_OFS_CFG);
  wire wr_pri = wr_acc && (PADDR == `FEE_OFS_PRIO);
  wire wr_hcs = wr_acc && (PADDR == `FEE_OFS_HCS);
  wire wr_bes = wr_acc && (PADDR == `FEE_OFS_BESTAT);
  wire mapped = (PADDR == `FEE_OFS_CFG) || (PADDR == `FEE_OFS_PRIO) || (PADDR == `FEE_OFS_HCS) ||
                (PADDR == `FEE_OFS_BESTAT) || (PADDR == `FEE_OFS_STATE);

  // ********************************************************
  // Fault classification
  // ********************************************************
  wire ev_mp = MPU_VIOLATION;                                         // RULE20
  wire ev_be_prec = BUS_ERR_PRECISE & ~BUS_ERR_DEBUG;                 // RULE13 RULE21
  wire ev_be = ev_be_prec | BUS_ERR_IMPRECISE;                        // RULE16
  wire ev_pu = UNDEF_INSTR | UNALIGNED_MULTI |
               (UNALIGNED_SINGLE & trap_unal_ff) |
               (DIV_BY_ZERO & trap_div_ff);                           // RULE22 RULE23
  wire in_fault = act_mp_ff | act_be_ff | act_pu_ff;
  wire in_top   = act_caf_ff | (CUR_EXC == `FEE_EXC_NMI);

  // Synchronous faults escalate when disabled or not above running level
  wire esc_mp = ev_mp & (~ena_mp_ff | ~preempts(lvl_mp, CUR_LEVEL));  // RULE6 RULE7 RULE8 RULE9
  wire esc_pu = ev_pu & (~ena_pu_ff | ~preempts(lvl_pu, CUR_LEVEL));  // RULE6 RULE7 RULE8 RULE9
  // Bus error on its own handler's push is kept, never escalated
  wire esc_bp = ev_be_prec & ~BUS_ERR_BE_PUSH &
                (~ena_be_ff | ~preempts(lvl_be, CUR_LEVEL));          // RULE10 RULE4
  wire esc_bi = BUS_ERR_IMPRECISE & ~ena_be_ff;                       // RULE18

  // ********************************************************
  // Pend, escalation and lockup decisions
  // ********************************************************
  always @* begin
    nxt_pend_mp  = pend_mp_ff;
    nxt_pend_be  = pend_be_ff;
    nxt_pend_pu  = pend_pu_ff;
    nxt_pend_caf = pend_caf_ff;
    nxt_caf_imp  = caf_imp_ff;
    nxt_lockup   = LOCKUP;
    // Software writes first so that a same-cycle hardware event wins
    if (wr_hcs) begin
      nxt_pend_mp = PWDATA[`FEE_HCS_MP_PEND];
      nxt_pend_be = PWDATA[`FEE_HCS_BE_PEND];
      nxt_pend_pu = PWDATA[`FEE_HCS_PU_PEND];
    end
    // Take clears before events so that a new fault in the take cycle is kept
    if (TAKE_VALID && (TAKE_EXC == `FEE_EXC_MPF)) nxt_pend_mp = 1'b0;
    if (TAKE_VALID && (TAKE_EXC == `FEE_EXC_BEF)) nxt_pend_be = 1'b0;
    if (TAKE_VALID && (TAKE_EXC == `FEE_EXC_PUF)) nxt_pend_pu = 1'b0;
    if (TAKE_VALID && (TAKE_EXC == `FEE_EXC_CAF)) nxt_pend_caf = 1'b0;
    if (ev_mp & ~esc_mp)
      nxt_pend_mp = 1'b1;                                             // RULE2
    if (ev_pu & ~esc_pu)
      nxt_pend_pu = 1'b1;
    if ((ev_be_prec & ~esc_bp) | (BUS_ERR_IMPRECISE & ena_be_ff))
      nxt_pend_be = 1'b1;                                             // RULE16
    // Synchronous escalation inside NMI or catch-all cannot be served
    if (in_top & (esc_mp | esc_pu | esc_bp | ev_be_prec))
      nxt_lockup = 1'b1;                                              // RULE14 RULE11
    else if (esc_mp | esc_pu | esc_bp) begin
      nxt_pend_caf = 1'b1;                                            // RULE4
      nxt_caf_imp  = 1'b0;
    end
    if (esc_bi) begin
      nxt_pend_caf = 1'b1;                                            // RULE18
      if (~(esc_mp | esc_pu | esc_bp))
        nxt_caf_imp = 1'b1;                                           // RULE19
    end
  end

  // ********************************************************
  // Arbitration of pended faults
  // ********************************************************
  // Checks are ordered so that a tie keeps the lowest exception number
  always @* begin
    nxt_take = `FEE_EXC_NONE;
    if (~MASK_ALL) begin
      if (pend_caf_ff & ~act_caf_ff & $signed(`FEE_LVL_CAF) < $signed(CUR_LEVEL))
        nxt_take = `FEE_EXC_CAF;                                      // RULE1 RULE11
      else if (~MASK_FAULT) begin                                     // RULE5
        if (pend_mp_ff & ena_mp_ff & preempts(lvl_mp, CUR_LEVEL) &
            ~(pend_be_ff & ena_be_ff & (lvl_be < lvl_mp)) &
            ~(pend_pu_ff & ena_pu_ff & (lvl_pu < lvl_mp)))
          nxt_take = `FEE_EXC_MPF;                                    // RULE25
        else if (pend_be_ff & ena_be_ff & preempts(lvl_be, CUR_LEVEL) &
                 ~(pend_pu_ff & ena_pu_ff & (lvl_pu < lvl_be)))
          nxt_take = `FEE_EXC_BEF;                                    // RULE25
        else if (pend_pu_ff & ena_pu_ff & preempts(lvl_pu, CUR_LEVEL))
          nxt_take = `FEE_EXC_PUF;
      end
      // A higher interrupt goes first; the pended fault waits
      if (IRQ_REQ && (nxt_take != `FEE_EXC_CAF) &&
          ($signed(IRQ_LEVEL) < $signed({2'b00, (nxt_take == `FEE_EXC_MPF) ? lvl_mp :
                                                (nxt_take == `FEE_EXC_BEF) ? lvl_be : lvl_pu})))
        nxt_take = `FEE_EXC_NONE;                                     // RULE17
    end
  end

  // ********************************************************
  // State registers
  // ********************************************************
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prio_ff      <= `FEE_RESET_ZERO;
      trap_div_ff  <= 1'b0;
      trap_unal_ff <= 1'b0;
      ena_mp_ff    <= 1'b0;                                           // RULE3
      ena_be_ff    <= 1'b0;
      ena_pu_ff    <= 1'b0;
      pend_mp_ff   <= 1'b0;
      pend_be_ff   <= 1'b0;
      pend_pu_ff   <= 1'b0;
      pend_caf_ff  <= 1'b0;
      act_mp_ff    <= 1'b0;
      act_be_ff    <= 1'b0;
      act_pu_ff    <= 1'b0;
      act_caf_ff   <= 1'b0;
      bes_prec_ff  <= 1'b0;
      bes_imp_ff   <= 1'b0;
      caf_imp_ff   <= 1'b0;
      LOCKUP       <= 1'b0;
      TAKE_VALID   <= 1'b0;
      TAKE_EXC     <= `FEE_EXC_NONE;
    end else begin
      if (wr_cfg) begin
        trap_unal_ff <= PWDATA[`FEE_CFG_UNALIGN];                     // RULE23
        trap_div_ff  <= PWDATA[`FEE_CFG_DIV0];
      end
      if (wr_pri)
        prio_ff <= {8'h00, PWDATA[23:0]};                             // RULE2
      if (wr_hcs) begin
        ena_mp_ff <= PWDATA[`FEE_HCS_MP_ENA];                         // RULE24
        ena_be_ff <= PWDATA[`FEE_HCS_BE_ENA];
        ena_pu_ff <= PWDATA[`FEE_HCS_PU_ENA];
      end
      pend_mp_ff  <= nxt_pend_mp;
      pend_be_ff  <= nxt_pend_be;
      pend_pu_ff  <= nxt_pend_pu;
      pend_caf_ff <= nxt_pend_caf;
      caf_imp_ff  <= nxt_caf_imp;
      // Lockup in an imprecise-origin catch-all is held off only in cycles with no precise bus, protection or usage fault event
      LOCKUP      <= LOCKUP | (nxt_lockup & ~(act_caf_ff & caf_imp_ff & ~ev_be_prec
                                              & ~ev_mp & ~ev_pu));    // RULE19
      // Write-one-to-clear; set beats clear
      bes_prec_ff <= ev_be_prec | (bes_prec_ff & ~(wr_bes & PWDATA[`FEE_BES_PRECISE]));     // RULE12
      bes_imp_ff  <= BUS_ERR_IMPRECISE | (bes_imp_ff & ~(wr_bes & PWDATA[`FEE_BES_IMPRECISE]));
      // Active tracking: set on take, cleared on return from that handler
      if (TAKE_VALID && (TAKE_EXC == `FEE_EXC_MPF)) act_mp_ff <= 1'b1;
      else if (EXC_RETURN && (CUR_EXC == `FEE_EXC_MPF)) act_mp_ff <= 1'b0;
      if (TAKE_VALID && (TAKE_EXC == `FEE_EXC_BEF)) act_be_ff <= 1'b1;
      else if (EXC_RETURN && (CUR_EXC == `FEE_EXC_BEF)) act_be_ff <= 1'b0;
      if (TAKE_VALID && (TAKE_EXC == `FEE_EXC_PUF)) act_pu_ff <= 1'b1;
      else if (EXC_RETURN && (CUR_EXC == `FEE_EXC_PUF)) act_pu_ff <= 1'b0;
      if (TAKE_VALID && (TAKE_EXC == `FEE_EXC_CAF)) act_caf_ff <= 1'b1;
      else if (EXC_RETURN && (CUR_EXC == `FEE_EXC_CAF)) act_caf_ff <= 1'b0;
      // Take is a one-cycle pulse; nothing is taken while locked up
      TAKE_VALID <= (nxt_take != `FEE_EXC_NONE) & ~TAKE_VALID & ~LOCKUP;
      TAKE_EXC   <= (TAKE_VALID | LOCKUP) ? `FEE_EXC_NONE : nxt_take;
    end
  end

  // ********************************************************
  // Side outputs: quiet divide and debug-only bus errors
  // ********************************************************
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DIV_ZERO_QUIET <= 1'b0;
      DEBUG_BUS_ERR  <= 1'b0;
    end else begin
      DIV_ZERO_QUIET <= DIV_BY_ZERO & ~trap_div_ff;                   // RULE23
      DEBUG_BUS_ERR  <= BUS_ERR_DEBUG & BUS_ERR_PRECISE;              // RULE15
    end
  end

  // ********************************************************
  // APB slave: one wait state, read mux, error on unmapped
  // ********************************************************
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= `FEE_PSLVERR_OK;
      PRDATA  <= `FEE_RESET_ZERO;
    end else begin
      PREADY  <= acc;
      PSLVERR <= acc & ~mapped;
      PRDATA  <= `FEE_RESET_ZERO;
      if (acc & ~PWRITE) begin
        case (PADDR)
          `FEE_OFS_CFG:    PRDATA <= {27'h0, trap_div_ff, trap_unal_ff, 3'h0};
          `FEE_OFS_PRIO:   PRDATA <= prio_ff;
          `FEE_OFS_HCS:    PRDATA <= {13'h0, ena_pu_ff, ena_be_ff, ena_mp_ff, 1'b0,
                                      pend_be_ff, pend_mp_ff, pend_pu_ff, 8'h0,
                                      act_pu_ff, 1'b0, act_be_ff, act_mp_ff};  // RULE24
          `FEE_OFS_BESTAT: PRDATA <= {29'h0, bes_imp_ff, bes_prec_ff, 1'b0};   // RULE12
          `FEE_OFS_STATE:  PRDATA <= {26'h0, in_fault, caf_imp_ff, pend_caf_ff,
                                      act_caf_ff, LOCKUP, 1'b0};
          default:         PRDATA <= `FEE_RESET_ZERO;
        endcase
      end
    end
  end

endmodule // fee_fault_unit

// ===== core/fee_regs.vh
/*
  Constants of the fault exception unit: register offsets, field positions,
  reset values, exception numbers and fixed levels.
  Assumes inclusion by bare name from the unit's design file.
*/
`ifndef FEE_REGS_VH
`define FEE_REGS_VH

// ********************************************************
// Register byte offsets (APB, one aligned word each)
// ********************************************************
`define FEE_OFS_CFG       12'h000
`define FEE_OFS_PRIO      12'h004
`define FEE_OFS_HCS       12'h008
`define FEE_OFS_BESTAT    12'h00C
`define FEE_OFS_STATE     12'h010

// ********************************************************
// Config control fields
// ********************************************************
`define FEE_CFG_UNALIGN   3
`define FEE_CFG_DIV0      4

// ********************************************************
// Handler control state fields
// ********************************************************
`define FEE_HCS_MP_ACT    0
`define FEE_HCS_BE_ACT    1
`define FEE_HCS_PU_ACT    3
`define FEE_HCS_PU_PEND   12
`define FEE_HCS_MP_PEND   13
`define FEE_HCS_BE_PEND   14
`define FEE_HCS_MP_ENA    16
`define FEE_HCS_BE_ENA    17
`define FEE_HCS_PU_ENA    18

// ********************************************************
// Bus error status fields
// ********************************************************
`define FEE_BES_PRECISE   1
`define FEE_BES_IMPRECISE 2

// ********************************************************
// Priority register fields (8 bits per fault)
// ********************************************************
`define FEE_PRIO_MP_LSB   0
`define FEE_PRIO_BE_LSB   8
`define FEE_PRIO_PU_LSB   16

// ********************************************************
// Exception numbers and fixed levels
// ********************************************************
`define FEE_EXC_NONE      4'h0
`define FEE_EXC_NMI       4'h2
`define FEE_EXC_CAF       4'h3
`define FEE_EXC_MPF       4'h4
`define FEE_EXC_BEF       4'h5
`define FEE_EXC_PUF       4'h6
// Signed 10-bit level: NMI -2, catch-all -1, thread idle 256
`define FEE_LVL_NMI       10'h3FE
`define FEE_LVL_CAF       10'h3FF
`define FEE_LVL_IDLE      10'h100

`define FEE_RESET_ZERO    32'h00000000
`define FEE_PSLVERR_OK    1'b0

`endif

// ===== testbench/fee_chk_assertions.sv
/* Checker on the fault unit ports.
   Assumes it is bound onto fee_fault_unit. */
`timescale 1ns/1ps
module fee_chk_assertions (
  input wire        SYS_CLK,
  input wire        RST_N,
  input wire        PSEL,
  input wire        PENABLE,
  input wire [11:0] PADDR,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire        BUS_ERR_PRECISE,
  input wire        BUS_ERR_DEBUG,
  input wire        DIV_BY_ZERO,
  input wire [3:0]  CUR_EXC,
  input wire        TAKE_VALID,
  input wire [3:0]  TAKE_EXC,
  input wire        DIV_ZERO_QUIET,
  input wire        DEBUG_BUS_ERR,
  input wire        LOCKUP
);
  // ********************************
  // Port relations
  // ********************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  apb_answer_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready not one cycle after access");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  bad_addr_a: assert property (PSLVERR |-> PREADY
    && !(PADDR inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010}))
    else $error("slave error on mapped address");
  take_num_a: assert property (TAKE_VALID |-> TAKE_EXC inside {4'h3, 4'h4, 4'h5, 4'h6})
    else $error("take with bad number");
  take_gap_a: assert property (TAKE_VALID |=> !TAKE_VALID)
    else $error("takes back to back");
  lock_hold_a: assert property (LOCKUP |=> LOCKUP && !TAKE_VALID)
    else $error("lockup dropped or take in lockup");
  nmi_lock_a: assert property (BUS_ERR_PRECISE && !BUS_ERR_DEBUG && CUR_EXC == 4'h2 |=> LOCKUP)
    else $error("no lockup on precise error in nmi");
  dbg_err_a: assert property (BUS_ERR_PRECISE && BUS_ERR_DEBUG |=> DEBUG_BUS_ERR)
    else $error("debugger error not reported");
  dbg_src_a: assert property (DEBUG_BUS_ERR |-> $past(BUS_ERR_PRECISE && BUS_ERR_DEBUG))
    else $error("debug report without cause");
  div_src_a: assert property (DIV_ZERO_QUIET |-> $past(DIV_BY_ZERO))
    else $error("quiet divide without cause");
  take_c: cover property (TAKE_VALID && TAKE_EXC == 4'h3);
  lock_c: cover property ($rose(LOCKUP));
  err_c: cover property (PSLVERR);
  quiet_c: cover property (DIV_ZERO_QUIET);
endmodule // fee_chk_assertions

bind fee_fault_unit fee_chk_assertions fee_chk_assertions_i (.*);

// ===== testbench/fee_fault_unit_bench.sv
/* Bench for the fault unit: APB tasks, event pulses, one task per scenario.
   Assumes the pipeline model answers takes and returns. */
`timescale 1ns/1ps
module fee_fault_unit_bench;
  reg         clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  reg  [11:0] padr = 12'h000;
  reg  [31:0] pwd = 32'h0, rq;
  reg  [8:0]  ev = 9'h000;
  reg  [23:0] prio = 24'h302010;
  reg  [9:0]  irq_lvl = 10'h005;
  reg         mask_f = 1'b0, irq_req = 1'b0, nmi_go = 1'b0, ret_go = 1'b0, re;
  wire [31:0] prd;
  wire [9:0]  lvl;
  wire [3:0]  exc, te;
  wire        prdy, perr, tv, dq, dbe, lk, ret;
  integer     n_errors = 0, check_count = 0;
  fee_fault_unit fee_fault_unit_i (
    .SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .MPU_VIOLATION(ev[0]), .BUS_ERR_PRECISE(ev[1]), .BUS_ERR_IMPRECISE(ev[2]),
    .BUS_ERR_DEBUG(ev[3]), .BUS_ERR_BE_PUSH(ev[4]), .UNDEF_INSTR(ev[5]),
    .UNALIGNED_MULTI(ev[6]), .UNALIGNED_SINGLE(ev[7]), .DIV_BY_ZERO(ev[8]),
    .CUR_LEVEL(lvl), .CUR_EXC(exc), .MASK_ALL(1'b0), .MASK_FAULT(mask_f),
    .IRQ_LEVEL(irq_lvl), .IRQ_REQ(irq_req), .EXC_RETURN(ret), .TAKE_VALID(tv),
    .TAKE_EXC(te), .DIV_ZERO_QUIET(dq), .DEBUG_BUS_ERR(dbe), .LOCKUP(lk));
  fee_pipe_model fee_pipe_model_i (
    .clk(clk), .rst_n(rst_n), .take_v(tv), .take_e(te), .nmi_go(nmi_go),
    .ret_go(ret_go), .prio(prio), .lvl_ff(lvl), .exc_ff(exc), .ret_ff(ret));
  // ********************************
  // Shared tasks
  // ********************************
  initial forever #2.5 clk = ~clk;
  task check(input string nm, input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // Holds the request until ready is seen high at a rising edge
  task apb(input w, input [11:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge clk);
      {psel, pwr, padr, pwd} <= {1'b1, w, a, d};
      @(posedge clk);
      pen <= 1'b1;
      i = 0;
      do begin
        @(posedge clk);
        i = i + 1;
      end while (prdy !== 1'b1 && i < 20);
      if (prdy !== 1'b1) n_errors = n_errors + 1;
      {rq, re} = {prd, perr};
      {psel, pen} <= 2'b00;
    end
  endtask
  task rd(input [11:0] a, input [31:0] x);
    begin
      apb(1'b0, a, 32'h0);
      check("reg", rq, x);
    end
  endtask
  task fire(input [8:0] x);
    begin
      @(posedge clk);
      ev <= x;
      @(posedge clk);
      ev <= 9'h000;
    end
  endtask
  // Exception taken within eight cycles, none when x is zero
  task take(input [3:0] x);
    integer i;
    reg [3:0] s;
    begin
      s = 4'h0;
      for (i = 0; i < 8 && s == 4'h0; i = i + 1) begin
        @(negedge clk);
        if (tv === 1'b1) s = te;
      end
      check("take", {28'h0, s}, {28'h0, x});
    end
  endtask
  task ret_h;
    begin
      @(posedge clk);
      ret_go <= 1'b1;
      @(posedge clk);
      ret_go <= 1'b0;
    end
  endtask
  // ********************************
  // Scenarios
  // ********************************
  task t_regs;
    begin
      rd(12'h000, 32'h0);
      rd(12'h008, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      check("slverr", {31'h0, re}, 32'h1);
      check("unmapped", rq, 32'h0);
      fire(9'h001);
      take(4'h3);
      ret_h;
    end
  endtask
  task t_nest;
    begin
      apb(1'b1, 12'h004, {8'h00, prio});
      apb(1'b1, 12'h008, 32'h00070000);
      fire(9'h001);
      take(4'h4);
      rd(12'h008, 32'h00070001);
      fire(9'h001);
      take(4'h3);
      ret_h;
      fire(9'h020);
      take(4'h3);
      ret_h;
      ret_h;
      @(posedge clk) prio <= 24'h102010;
      apb(1'b1, 12'h004, 32'h00102010);
      fire(9'h021);
      take(4'h4);
      ret_h;
      take(4'h6);
      ret_h;
    end
  endtask
  task t_mask_irq;
    begin
      @(posedge clk) mask_f <= 1'b1;
      fire(9'h001);
      take(4'h0);
      @(posedge clk) mask_f <= 1'b0;
      take(4'h4);
      ret_h;
      @(posedge clk) irq_req <= 1'b1;
      fire(9'h004);
      take(4'h0);
      @(posedge clk) irq_req <= 1'b0;
      take(4'h5);
      ret_h;
      rd(12'h00C, 32'h4);
      apb(1'b1, 12'h008, 32'h00050000);
      fire(9'h004);
      take(4'h3);
      ret_h;
      apb(1'b1, 12'h008, 32'h00070000);
      apb(1'b1, 12'h00C, 32'h6);
      rd(12'h00C, 32'h0);
    end
  endtask
  task t_div_dbg;
    begin
      fire(9'h180);
      @(negedge clk) check("quiet", {31'h0, dq}, 32'h1);
      take(4'h0);
      fire(9'h040);
      take(4'h6);
      ret_h;
      apb(1'b1, 12'h000, 32'h18);
      fire(9'h100);
      take(4'h6);
      ret_h;
      fire(9'h080);
      take(4'h6);
      ret_h;
      fire(9'h00A);
      @(negedge clk) check("dbg", {31'h0, dbe}, 32'h1);
      take(4'h0);
    end
  endtask
  task t_bus_lock;
    begin
      fire(9'h002);
      take(4'h5);
      rd(12'h00C, 32'h2);
      fire(9'h012);
      take(4'h0);
      @(posedge clk) nmi_go <= 1'b1;
      @(posedge clk) nmi_go <= 1'b0;
      fire(9'h002);
      @(negedge clk) check("lock", {31'h0, lk}, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      check("state", {31'h0, rq[1]}, 32'h1);
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // Main sequence, then a watchdog far beyond its length
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_nest;
    t_mask_irq;
    t_div_dbg;
    t_bus_lock;
    results;
  end
  initial begin
    #100000;
    n_errors = n_errors + 1;
    results;
  end
endmodule // fee_fault_unit_bench

// ===== testbench/fee_pipe_model.sv
/* Pipeline model: enters handlers on takes, two-deep return stack.
   Assumes the bench pulses nmi_go and ret_go. */
`timescale 1ns/1ps
module fee_pipe_model (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        take_v,
  input  wire [3:0]  take_e,
  input  wire        nmi_go,
  input  wire        ret_go,
  input  wire [23:0] prio,
  output reg  [9:0]  lvl_ff,
  output reg  [3:0]  exc_ff,
  output reg         ret_ff
);
  reg  [13:0] s1_ff, s2_ff;
  reg  [9:0]  nxt_lvl;
  wire [3:0]  nxt_exc = nmi_go ? 4'h2 : take_e;
  // Level of the handler being entered
  always @* begin
    case (nxt_exc)
      4'h2: nxt_lvl = 10'h3FE;
      4'h3: nxt_lvl = 10'h3FF;
      4'h4: nxt_lvl = {2'b00, prio[7:0]};
      4'h5: nxt_lvl = {2'b00, prio[15:8]};
      default: nxt_lvl = {2'b00, prio[23:16]};
    endcase
  end
  // Return pulse shows while the old handler runs; nests past two are lost
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {exc_ff, lvl_ff, ret_ff} <= {4'h0, 10'h100, 1'b0};
      s1_ff <= {4'h0, 10'h100};
      s2_ff <= {4'h0, 10'h100};
    end else begin
      ret_ff <= ret_go;
      if (ret_ff)
        {exc_ff, lvl_ff, s1_ff} <= {s1_ff, s2_ff};
      else if (take_v || nmi_go) begin
        {s2_ff, s1_ff} <= {s1_ff, exc_ff, lvl_ff};
        {exc_ff, lvl_ff} <= {nxt_exc, nxt_lvl};
      end
    end
  end
endmodule // fee_pipe_model
